/* File: srb_pkg.sv */
package srb_pkg;
   localparam logic [4:0] SEL_INT   = 5'h05;
   localparam logic [4:0] SEL_FRACL = 5'h06;
   localparam logic [4:0] SEL_REF   = 5'h07;
   localparam logic [4:0] SEL_CALD  = 5'h08;
   localparam logic [4:0] SEL_CALS  = 5'h09;
   localparam logic [4:0] SEL_RSVD  = 5'h0A;
   localparam logic [4:0] SEL_RAMP  = 5'h0B;
   localparam logic [4:0] SEL_CP    = 5'h0C;
   localparam logic [4:0] SEL_RCLK  = 5'h0D;
   localparam logic [4:0] SEL_DEV   = 5'h0E;
   localparam int REG_LO = 5;
   localparam int REG_HI = 14;
   localparam int SEL_MSB = 4;
   localparam int INT_MSB = 28;
   localparam int INT_LSB = 17;
   localparam int FRACH_MSB = 16;
   localparam int FRACL_MSB = 17;
   localparam int FIELD_LSB = 5;
   localparam int RAMP_ON_BIT = 29;
   localparam int MRST_BIT = 25;
   localparam int CAL_CLOCK_DIVIDER_MSB = 23;
   localparam int CAL_CLOCK_DIVIDER_LSB = 12;
   localparam int HALF_BIT = 11;
   localparam int DBL_BIT = 10;
   localparam int RCNT_MSB = 19;
   localparam int RCNT_LSB = 15;
   localparam int CALD_MSB = 14;
   localparam int SDRST_BIT = 11;
   localparam int TRI1_BIT = 9;
   localparam int MODE_MSB = 8;
   localparam int MODE_LSB = 7;
   localparam int CNTR_BIT = 5;
   localparam int CP_MSB = 20;
   localparam int CP_LSB = 17;
   localparam int CPTRI_BIT = 15;
   localparam int LESYNC_BIT = 21;
   localparam int CDM_MSB = 20;
   localparam int CDM_LSB = 19;
   localparam int RAMP_STEP_DIVIDER_MSB = 18;
   localparam int RAMP_STEP_DIVIDER_LSB = 7;
   localparam int CDS_MSB = 6;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCLK_HALF_NS = 50;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WORD_BITS = 32;
   localparam logic [3:0] ADDR_DATA = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_LOAD} srb_state_t;
endpackage

/* File: srb_link_if.sv */
`timescale 1ns/10ps
interface srb_link_if;
   logic serial_clock;
   logic serial_data;
   logic serial_load_strobe;
   modport host (output serial_clock, output serial_data, output serial_load_strobe);
   modport device (input serial_clock, input serial_data, input serial_load_strobe);
endinterface

/* File: srb_device.sv */
// Overview of operation
// - integer divide from bits 28..17, 75..4095
// - fraction: high 12 bits, low 13 bits
// - select 00110, 00111, 01000 route words
// - select 01011, 01100, 01101 route words
// - select 01110 routes deviation word
// - reference bit 25 holds all other words and the counters in reset
// - bits 23..12 calibration clock divider
// - bit 11 adds divide-by-two toggle stage
// - bit 10 chooses falling or both edges
// - 5-bit reference counter, ratios 1..31
// - bits 14..5 frequency calibration divider
// - host writes calibration setup fixed words
// - host writes reserved word fixed value
// - bit 11 low resets modulator per write
// - bit 9 single triangle, mode 11 only
// - ramp mode from bits 8..7
// - bit 5 holds counters in reset
// - charge pump current bits 20..17
// - bit 15 tristates charge pump
// - bit 21 syncs load strobe to reference
// - host sets divider mode 11 for ramps
// - step divider bits 18..7, segment 6..5
// - integer word bit 29 starts ramp
`timescale 1ns/10ps
module srb_device
   import srb_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   srb_link_if.device       link,
   input  wire logic        reference_input,
   output logic [11:0]      integer_value,
   output logic [24:0]      fractional_value,
   output logic             ramp_on,
   output logic             master_reset,
   output logic [11:0]      cal_clock_divider,
   output logic             reference_half_divide,
   output logic             doubler_enable,
   output logic [4:0]       ref_count_ratio,
   output logic             cal_ref_tick,
   output logic [9:0]       cal_freq_divider,
   output logic [31:0]      cal_setup_word,
   output logic [31:0]      reserved_word,
   output logic             sigma_delta_reset,
   output logic             single_triangle,
   output logic [1:0]       ramp_mode,
   output logic             counter_clear_bit,
   output logic [3:0]       cp_current,
   output logic             cp_tristate,
   output logic             load_sync_enable,
   output logic [1:0]       divider_mode_field,
   output logic [11:0]      ramp_step_divider,
   output logic [1:0]       clk_div_select,
   output logic [31:0]      deviation_word
);
   logic [31:0] word_q [REG_LO:REG_HI];
   logic [31:0] shift_q;
   logic [31:0] cap_q;
   logic        sclk_d;
   logic        load_d;
   logic        pend_q;
   logic        ref_d;
   logic        ref_edge;
   logic        commit;
   logic [4:0]  sel;
   logic [4:0]  rcnt_q;
   logic        r_out;
   logic        tog_q;

   // only select codes of this bank are committed
   function automatic logic in_range(input logic [4:0] s);
      in_range = (s >= SEL_INT) && (s <= SEL_DEV);
   endfunction

   // serial word shifts in msb first on each rising serial clock
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sclk_d  <= 1'b0;
         shift_q <= RESET_WORD;
      end else begin
         sclk_d <= link.serial_clock;
         if (link.serial_clock && !sclk_d) begin
            shift_q <= {shift_q[30:0], link.serial_data};
         end
      end
   end

   // active reference edges: falling only, or both with doubler
   assign ref_edge = doubler_enable ? (reference_input != ref_d)
                                    : (!reference_input && ref_d);

   // capture on strobe rise, commit next cycle or at next reference edge
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         load_d <= 1'b0;
         pend_q <= 1'b0;
         cap_q  <= RESET_WORD;
      end else begin
         load_d <= link.serial_load_strobe;
         if (link.serial_load_strobe && !load_d) begin
            pend_q <= 1'b1;
            cap_q  <= shift_q;
         end else if (commit) begin
            pend_q <= 1'b0;
         end
      end
   end

   // without sync the commit follows the capture by one cycle
   assign commit = pend_q && (!load_sync_enable || ref_edge);
   assign sel = cap_q[SEL_MSB:0];

   // register map; master reset clears every word but the reference one
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = REG_LO; i <= REG_HI; i++) begin
            word_q[i] <= RESET_WORD;
         end
      end else begin
         if (commit && in_range(sel)) begin
            word_q[sel] <= cap_q;
         end
         // the clear comes last so it wins over a same-cycle commit
         if (master_reset) begin
            for (int i = REG_LO; i <= REG_HI; i++) begin
               if (i != int'(SEL_REF)) begin
                  word_q[i] <= RESET_WORD;
               end
            end
         end
      end
   end

   // modulator reset pulse on each integer word write unless bit 11 disables it or master reset is set
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sigma_delta_reset <= 1'b0;
      end else begin
         sigma_delta_reset <= commit && (sel == SEL_INT) && !master_reset
                              && !word_q[SEL_RAMP][SDRST_BIT];
      end
   end

   // reference counter and optional toggle stage toward calibration
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ref_d  <= 1'b0;
         rcnt_q <= 5'h00;
         tog_q  <= 1'b0;
         cal_ref_tick <= 1'b0;
      end else begin
         ref_d <= reference_input;
         if (master_reset || counter_clear_bit) begin
            rcnt_q <= 5'h00;
            tog_q  <= 1'b0;
            cal_ref_tick <= 1'b0;
         end else begin
            if (ref_edge) begin
               rcnt_q <= r_out ? 5'h00 : rcnt_q + 5'h01;
            end
            // toggle stage flips once per counter terminal
            if (r_out) begin
               tog_q <= !tog_q;
            end
            cal_ref_tick <= reference_half_divide ? (r_out && tog_q) : r_out;
         end
      end
   end

   // a ratio of zero behaves as a ratio of one
   assign r_out = ref_edge && ((rcnt_q + 5'h01 >= ref_count_ratio) || (ref_count_ratio == 5'h00));

   // master reset lives in the reference word so that it can be released
   assign master_reset          = word_q[SEL_REF][MRST_BIT];

   // integer word and both fraction halves
   assign integer_value         = word_q[SEL_INT][INT_MSB:INT_LSB];
   assign fractional_value      = {word_q[SEL_INT][FRACH_MSB:FIELD_LSB],
                                   word_q[SEL_FRACL][FRACL_MSB:FIELD_LSB]};
   assign ramp_on               = word_q[SEL_INT][RAMP_ON_BIT];

   // reference word fields
   assign cal_clock_divider     = word_q[SEL_REF][CAL_CLOCK_DIVIDER_MSB:CAL_CLOCK_DIVIDER_LSB];
   assign reference_half_divide = word_q[SEL_REF][HALF_BIT];
   assign doubler_enable        = word_q[SEL_REF][DBL_BIT];
   assign ref_count_ratio       = word_q[SEL_REF][RCNT_MSB:RCNT_LSB];

   // calibration divider and the fixed words
   assign cal_freq_divider      = word_q[SEL_CALD][CALD_MSB:FIELD_LSB];
   assign cal_setup_word        = word_q[SEL_CALS];
   assign reserved_word         = word_q[SEL_RSVD];

   // ramp control word
   assign single_triangle       = word_q[SEL_RAMP][TRI1_BIT];
   assign ramp_mode             = word_q[SEL_RAMP][MODE_MSB:MODE_LSB];
   assign counter_clear_bit     = word_q[SEL_RAMP][CNTR_BIT];

   // charge pump word
   assign cp_current            = word_q[SEL_CP][CP_MSB:CP_LSB];
   assign cp_tristate           = word_q[SEL_CP][CPTRI_BIT];

   // ramp clock divider word and deviation word
   assign load_sync_enable      = word_q[SEL_RCLK][LESYNC_BIT];
   assign divider_mode_field    = word_q[SEL_RCLK][CDM_MSB:CDM_LSB];
   assign ramp_step_divider     = word_q[SEL_RCLK][RAMP_STEP_DIVIDER_MSB:RAMP_STEP_DIVIDER_LSB];
   assign clk_div_select        = word_q[SEL_RCLK][CDS_MSB:FIELD_LSB];
   assign deviation_word        = word_q[SEL_DEV];
endmodule

/* File: srb_host.sv */
`timescale 1ns/10ps
module srb_host
   import srb_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   srb_link_if.host         link
);
   srb_state_t  state;
   logic [31:0] word_q;
   logic [5:0]  bits_q;
   logic [3:0]  div_q;
   logic        rd_ack;
   logic        busy;
   logic        start;
   logic        half_done;

   assign busy = (state != ST_IDLE);
   // fixed words (calibration setup, reserved) are sent as written by software
   assign start = avs_write && !busy && (avs_address == ADDR_DATA);
   assign avs_waitrequest = avs_read ? !rd_ack
                                     : (avs_write && busy && (avs_address == ADDR_DATA));
   assign half_done = (div_q == 4'(SCLK_HALF_CYC - 1));

   // reads answer one cycle after the request
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rd_ack       <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         rd_ack <= avs_read && !rd_ack;
         if (avs_read && !rd_ack) begin
            avs_readdata <= (avs_address == ADDR_STATUS) ? {31'h0000_0000, busy}
                                                         : 32'h0000_0000;
         end
      end
   end

   // serial engine: msb first, data changes while clock low
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state  <= ST_IDLE;
         word_q <= 32'h0000_0000;
         bits_q <= 6'h00;
         div_q  <= 4'h0;
         link.serial_clock       <= 1'b0;
         link.serial_data        <= 1'b0;
         link.serial_load_strobe <= 1'b0;
      end else begin
         div_q <= half_done ? 4'h0 : div_q + 4'h1;
         case (state)
            ST_IDLE: begin
               div_q <= 4'h0;
               if (start) begin
                  state  <= ST_SHIFT;
                  word_q <= {avs_writedata[30:0], 1'b0};
                  link.serial_data <= avs_writedata[31];
                  bits_q <= 6'h00;
               end
            end
            ST_SHIFT: begin
               if (half_done) begin
                  link.serial_clock <= !link.serial_clock;
                  if (link.serial_clock) begin
                     if (bits_q == 6'(WORD_BITS - 1)) begin
                        state <= ST_LOAD;
                        link.serial_load_strobe <= 1'b1;
                     end else begin
                        bits_q <= bits_q + 6'h01;
                        link.serial_data <= word_q[31];
                        word_q <= {word_q[30:0], 1'b0};
                     end
                  end
               end
            end
            ST_LOAD: begin
               if (half_done) begin
                  link.serial_load_strobe <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: srb_checker.sv */
`timescale 1ns/10ps
module srb_checker (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        serial_clock,
   input wire logic        serial_data,
   input wire logic        serial_load_strobe,
   input wire logic        master_reset,
   input wire logic [11:0] integer_value,
   input wire logic        sigma_delta_reset
);
   logic       sclk_q;
   logic       le_q;
   logic [5:0] rises;
   logic [7:0] since_le;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge sys_clk) begin
      sclk_q <= serial_clock;
      le_q <= serial_load_strobe;
   end
   // rising serial clock edges in the current frame
   always_ff @(posedge sys_clk) begin
      if (sys_rst || (le_q && !serial_load_strobe)) begin
         rises <= 6'h00;
      end else if (serial_clock && !sclk_q) begin
         rises <= rises + 6'h01;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         since_le <= 8'hFF;
      end else if (serial_load_strobe && !le_q) begin
         since_le <= 8'h00;
      end else if (since_le != 8'hFF) begin
         since_le <= since_le + 8'h01;
      end
   end
   property p_frame; $rose(serial_load_strobe) |-> rises == 6'h20; endproperty
   a_frame: assert property (p_frame) else $error("frame without 32 clocks");
   property p_le_len; $rose(serial_load_strobe) |-> serial_load_strobe[*5] ##1 !serial_load_strobe;
   endproperty
   a_le_len: assert property (p_le_len) else $error("strobe length wrong");
   property p_le_quiet; serial_load_strobe |-> !serial_clock; endproperty
   a_le_quiet: assert property (p_le_quiet) else $error("clock runs under strobe");
   property p_half; $rose(serial_clock) |-> serial_clock[*5] ##1 !serial_clock; endproperty
   a_half: assert property (p_half) else $error("clock high phase wrong");
   property p_hold; serial_clock && $past(serial_clock) |-> $stable(serial_data); endproperty
   a_hold: assert property (p_hold) else $error("data moved while clock high");
   property p_mrst; master_reset && $past(master_reset) |-> integer_value == 12'h000; endproperty
   a_mrst: assert property (p_mrst) else $error("word kept under master reset");
   property p_sd; sigma_delta_reset |-> since_le < 8'h28; endproperty
   a_sd: assert property (p_sd) else $error("modulator reset without a load");
   property p_sd_once; sigma_delta_reset |=> !sigma_delta_reset; endproperty
   a_sd_once: assert property (p_sd_once) else $error("modulator reset too long");
endmodule

/* File: synth_ramp_register_bank_tb_top.sv */
`timescale 1ns/10ps
module synth_ramp_register_bank_tb_top;
   import srb_pkg::*;
   logic         sys_clk;
   logic         sys_rst;
   logic [3:0]   avs_address;
   logic         avs_read;
   logic         avs_write;
   logic [31:0]  avs_writedata;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   logic         reference_input;
   logic         sigma_delta_reset;
   logic         cal_ref_tick;
   logic [189:0] outs;
   logic [31:0]  r [5:14];
   int           fail_count;
   int           tests_run;
   int           sd_cnt;
   int           sd_exp;
   srb_link_if link_if();
   srb_host srb_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link_if));
   srb_device srb_device_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_if),
      .reference_input(reference_input), .integer_value(outs[189:178]),
      .fractional_value(outs[177:153]), .ramp_on(outs[152]), .master_reset(outs[151]),
      .cal_clock_divider(outs[150:139]), .reference_half_divide(outs[138]),
      .doubler_enable(outs[137]), .ref_count_ratio(outs[136:132]), .cal_ref_tick(cal_ref_tick),
      .cal_freq_divider(outs[131:122]), .cal_setup_word(outs[121:90]),
      .reserved_word(outs[89:58]), .sigma_delta_reset(sigma_delta_reset),
      .single_triangle(outs[57]), .ramp_mode(outs[56:55]), .counter_clear_bit(outs[54]),
      .cp_current(outs[53:50]), .cp_tristate(outs[49]), .load_sync_enable(outs[48]),
      .divider_mode_field(outs[47:46]), .ramp_step_divider(outs[45:34]),
      .clk_div_select(outs[33:32]), .deviation_word(outs[31:0]));
   srb_checker srb_checker_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .serial_clock(link_if.serial_clock), .serial_data(link_if.serial_data),
      .serial_load_strobe(link_if.serial_load_strobe), .master_reset(outs[151]),
      .integer_value(outs[189:178]), .sigma_delta_reset(sigma_delta_reset));
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) reference_input <= ~reference_input;
   always @(posedge sys_clk) begin
      if (sigma_delta_reset === 1'b1) sd_cnt <= sd_cnt + 1;
   end
   task print_verdict;
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 1000);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 1000) begin
         chk(1'b0, "bus timeout");
         print_verdict;
      end
   endtask
   function logic [31:0] mk(input logic [4:0] c);
      logic [31:0] w;
      w = $urandom;
      w[4:0] = c;
      case (c)
         5'h05: w[28:17] = 12'h04B + 12'($urandom % 4021);
         5'h07: begin
            w[25] = 1'b0;
            if (w[19:15] == 5'h00) w[15] = 1'b1;
         end
         5'h09: w = w[0] ? 32'h2A20B929 : 32'h2800B929;
         5'h0A: w = 32'h1D32A64A;
         5'h0B: if (w[9]) w[8:7] = 2'b11;
         5'h0C: w[20] = 1'b0;
         5'h0D: w[20] = w[19];
         default: ;
      endcase
      return w;
   endfunction
   function logic [189:0] ex();
      return {r[5][28:17], r[5][16:5], r[6][17:5], r[5][29], r[7][25], r[7][23:12], r[7][11],
         r[7][10], r[7][19:15], r[8][14:5], r[9], r[10], r[11][9], r[11][8:7], r[11][5],
         r[12][20:17], r[12][15], r[13][21], r[13][20:19], r[13][18:7], r[13][6:5], r[14]};
   endfunction
   function int tick_period();
      int ratio;
      ratio = (r[7][19:15] == 5'h00) ? 1 : int'(r[7][19:15]);
      return (r[7][10] ? 1 : 2) * (r[7][11] ? 2 : 1) * ratio;
   endfunction
   task xfer(input logic [31:0] w);
      logic [31:0] q;
      av(1'b1, ADDR_DATA, w, q);
      if (w[4:0] == SEL_INT && !r[11][11] && !r[7][25]) sd_exp++;
      if (w[4:0] >= SEL_INT && w[4:0] <= SEL_DEV) r[w[4:0]] = w;
      if (r[7][25]) begin
         for (int i = 5; i < 15; i++) if (i != 7) r[i] = 32'h0;
      end
   endtask
   task settle;
      logic [31:0] q;
      int n;
      int ticks;
      int p;
      n = 0;
      q = 32'h1;
      while (q[0] !== 1'b0 && n < 400) begin
         av(1'b0, ADDR_STATUS, 32'h0, q);
         n++;
      end
      if (n >= 400) begin
         chk(1'b0, "busy stuck");
         print_verdict;
      end
      repeat (12) @(posedge sys_clk);
      chk(outs === ex(), "field mismatch");
      chk(sd_cnt === sd_exp, "modulator reset count");
      p = tick_period();
      ticks = 0;
      repeat (200) begin
         @(posedge sys_clk);
         if (cal_ref_tick === 1'b1) ticks++;
      end
      if (r[7][25] || r[11][5]) chk(ticks == 0, "calibration tick while held");
      else chk(ticks * p <= 200 + p && ticks * p + p >= 200, "tick rate");
   endtask
   initial begin
      logic [31:0] q;
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      reference_input = 1'b0;
      fail_count = 0;
      tests_run = 0;
      sd_cnt = 0;
      sd_exp = 0;
      for (int i = 5; i < 15; i++) r[i] = 32'h0;
      void'($urandom(29910));
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      chk(outs === ex(), "reset values");
      av(1'b0, 4'h8, 32'h0, q);
      chk(q === 32'h0, "unmapped read");
      av(1'b1, 4'h8, 32'hFFFFFFEB, q);
      settle;
      xfer(32'h1FFE0005);
      settle;
      xfer(32'h00960005);
      settle;
      for (int i = 0; i < 90; i++) begin
         xfer(mk(i < 10 ? 5'(i + 5) : 5'($urandom % 32)));
         if (i % 3 != 0) settle;
      end
      settle;
      xfer(32'h02000007);
      settle;
      xfer(mk(SEL_INT));
      settle;
      xfer(32'h00008007);
      settle;
      print_verdict;
   end
endmodule
